// ### verilog/wmap_mapper.sv
// multi-window address mapper: index/data register port, mapping ram with row and
// column maps, per-window bias and plane select, priority resolution per fetch.
// assumes every input is synchronous to i_clk_sys (display controller clocking).
`timescale 1ns/10ps

// Contract
// - index register at own i/o location
// - index advances after each data write
// - register 0 holds four 2-bit priorities
// - largest priority wins where windows overlap
// - all priorities zero bypasses windowing
// - bias low, high, plane per window
// - bias added to display address
// - three plane-enable bits per window
// - plane select zero shows background
// - geometry from cpu-unreachable row/column maps
// - 320-dot modes use even row addresses
// - column map half-dot in 200-raster hi-res
// - at most four windows supported
// - sync timing comes from display controller
module wmap_mapper #(
  parameter int NUM_WIN = wmap_pkg::WMAP_NUM_WIN,
  parameter int MAP_AW = wmap_pkg::WMAP_MAP_AW
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire wmap_pkg::wmap_io_t i_io,
  input wire wmap_pkg::wmap_map_wr_t i_map_wr,
  input wire wmap_pkg::wmap_fetch_t i_fetch,
  input wire logic i_mode_320,
  input wire logic i_mode_half_dot,
  output wmap_pkg::wmap_pix_t o_pix,
  output logic [3:0] o_reg_index
);
  import wmap_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [3:0] index_reg;
  logic [7:0] prio_reg;
  logic [15:0] bias_reg [NUM_WIN];
  logic [2:0] plane_reg [NUM_WIN];

  logic index_wr;
  logic data_wr;
  logic [3:0] win_off;
  logic [1:0] sel_win;
  logic [1:0] sel_fld;

  assign index_wr = i_io.wr && (i_io.addr == WMAP_IO_INDEX);
  assign data_wr = i_io.wr && (i_io.addr == WMAP_IO_DATA);
  assign win_off = index_reg - WMAP_IDX_FIRST_WIN;
  assign sel_win = 2'(win_off / WMAP_IDX_PER_WIN);
  assign sel_fld = 2'(win_off % WMAP_IDX_PER_WIN);

  // priority field of window w; window 0 sits in the top two bits
  function automatic logic [1:0] prio_of(input logic [7:0] p, input int w);
    prio_of = p[7 - 2 * w -: 2];
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      index_reg <= WMAP_RST_INDEX;
    end else if (index_wr) begin
      index_reg <= i_io.data[3:0];
    end else if (data_wr) begin
      // lets software load the first number only and stream the rest
      index_reg <= index_reg + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      prio_reg <= WMAP_RST_PRIO;
    end else if (data_wr && index_reg == WMAP_IDX_PRIO) begin
      prio_reg <= i_io.data;
    end
  end

  generate
    for (genvar w = 0; w < NUM_WIN; w++) begin : g_winreg
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          bias_reg[w] <= WMAP_RST_BIAS;
          plane_reg[w] <= WMAP_RST_PLANE;
        end else if (data_wr && index_reg >= WMAP_IDX_FIRST_WIN && index_reg <= WMAP_IDX_LAST &&
                     sel_win == 2'(w)) begin
          unique case (sel_fld)
            WMAP_FLD_BIAS_LO: bias_reg[w][7:0] <= i_io.data;
            WMAP_FLD_BIAS_HI: bias_reg[w][15:8] <= i_io.data;
            WMAP_FLD_PLANE: plane_reg[w] <= i_io.data[2:0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_index <= WMAP_RST_INDEX;
    end else begin
      o_reg_index <= index_wr ? i_io.data[3:0] : (data_wr ? index_reg + 4'h1 : index_reg);
    end
  end

  // ----------------------------------------------------------------
  // mapping ram
  // ----------------------------------------------------------------
  // written only from the display controller's memory port, never from the cpu port
  logic [NUM_WIN-1:0] row_map [2**MAP_AW];
  logic [NUM_WIN-1:0] col_map [2**MAP_AW];

  always_ff @(posedge i_clk_sys) begin
    if (i_map_wr.wr && !i_map_wr.is_col) begin
      row_map[i_map_wr.addr] <= i_map_wr.data[NUM_WIN-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_map_wr.wr && i_map_wr.is_col) begin
      col_map[i_map_wr.addr] <= i_map_wr.data[NUM_WIN-1:0];
    end
  end

  // ----------------------------------------------------------------
  // fetch stage 1: map lookup
  // ----------------------------------------------------------------
  logic [MAP_AW-1:0] row_addr;
  logic [MAP_AW-1:0] col_addr;
  logic [NUM_WIN-1:0] row_bits_reg;
  logic [NUM_WIN-1:0] col_bits_reg;
  logic s1_valid_reg;
  logic [WMAP_ADDR_W-1:0] s1_addr_reg;

  // in 320-dot modes a dot steps two row-map entries, so odd entries never get used
  assign row_addr = i_mode_320 ? {i_fetch.hpos[MAP_AW-2:0], 1'b0} : i_fetch.hpos;
  // half-dot mode interleaves the half-dot phase into the column-map address
  assign col_addr = i_mode_half_dot ? {i_fetch.vpos, i_fetch.half_phase} : {1'b0, i_fetch.vpos};

  always_ff @(posedge i_clk_sys) begin
    row_bits_reg <= row_map[row_addr];
    col_bits_reg <= col_map[col_addr];
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_valid_reg <= 1'b0;
      s1_addr_reg <= '0;
    end else begin
      // fetch timing is the display controller's own; this block adds a fixed delay only
      s1_valid_reg <= i_fetch.valid;
      s1_addr_reg <= i_fetch.addr;
    end
  end

  // ----------------------------------------------------------------
  // fetch stage 2: window resolution
  // ----------------------------------------------------------------
  logic bypass;
  logic any_hit;
  logic [1:0] best_win;
  logic [1:0] best_prio;
  logic [NUM_WIN-1:0] hit;

  assign bypass = (prio_reg == WMAP_RST_PRIO);
  assign hit = row_bits_reg & col_bits_reg;

  // on equal priority the lower-numbered window is kept
  always_comb begin
    any_hit = 1'b0;
    best_win = 2'h0;
    best_prio = 2'h0;
    for (int w = 0; w < NUM_WIN; w++) begin
      if (hit[w] && (!any_hit || prio_of(prio_reg, w) > best_prio)) begin
        any_hit = 1'b1;
        best_win = 2'(w);
        best_prio = prio_of(prio_reg, w);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pix <= '0;
    end else begin
      o_pix.valid <= s1_valid_reg;
      if (bypass) begin
        // software must pick planes for the bypass case; window 0's select is used
        o_pix.addr <= s1_addr_reg;
        o_pix.plane_en <= plane_reg[0];
        o_pix.background <= (plane_reg[0] == 3'h0);
        o_pix.win_hit <= 1'b0;
        o_pix.win_id <= 2'h0;
      end else if (any_hit) begin
        o_pix.addr <= WMAP_ADDR_W'(s1_addr_reg + {2'h0, bias_reg[best_win]});
        o_pix.plane_en <= plane_reg[best_win];
        o_pix.background <= (plane_reg[best_win] == 3'h0);
        o_pix.win_hit <= 1'b1;
        o_pix.win_id <= best_win;
      end else begin
        // outside every window: no planes shown, border colour is chosen downstream
        o_pix.addr <= s1_addr_reg;
        o_pix.plane_en <= 3'h0;
        o_pix.background <= 1'b0;
        o_pix.win_hit <= 1'b0;
        o_pix.win_id <= 2'h0;
      end
    end
  end
endmodule

// ### verilog/wmap_pkg.sv
// package for the multi-window address mapper: register indices, field layout,
// reset values and the carriers that link the mapper to the cpu port and the fetch path.
// assumes a single clock domain shared with the display controller.
package wmap_pkg;
  localparam int WMAP_NUM_WIN = 4;
  localparam int WMAP_ADDR_W = 18;
  localparam int WMAP_MAP_AW = 11;

  // i/o locations of the cpu-side ports
  localparam logic [8:0] WMAP_IO_INDEX = 9'h110;
  localparam logic [8:0] WMAP_IO_DATA = 9'h112;

  // internal register numbers reached through the data port
  localparam logic [3:0] WMAP_IDX_PRIO = 4'h0;
  localparam logic [3:0] WMAP_IDX_FIRST_WIN = 4'h1;
  localparam logic [3:0] WMAP_IDX_LAST = 4'hC;
  localparam logic [3:0] WMAP_IDX_PER_WIN = 4'h3;

  // field positions inside a window's three-byte group
  localparam logic [1:0] WMAP_FLD_BIAS_LO = 2'h0;
  localparam logic [1:0] WMAP_FLD_BIAS_HI = 2'h1;
  localparam logic [1:0] WMAP_FLD_PLANE = 2'h2;

  // reset values
  localparam logic [3:0] WMAP_RST_INDEX = 4'h0;
  localparam logic [7:0] WMAP_RST_PRIO = 8'h00;
  localparam logic [15:0] WMAP_RST_BIAS = 16'h0000;
  localparam logic [2:0] WMAP_RST_PLANE = 3'h7;

  typedef struct packed {
    logic wr;
    logic [8:0] addr;
    logic [7:0] data;
  } wmap_io_t;

  typedef struct packed {
    logic wr;
    logic is_col;
    logic [WMAP_MAP_AW-1:0] addr;
    logic [WMAP_NUM_WIN-1:0] data;
  } wmap_map_wr_t;

  typedef struct packed {
    logic valid;
    logic [WMAP_ADDR_W-1:0] addr;
    logic [WMAP_MAP_AW-1:0] hpos;
    logic [WMAP_MAP_AW-2:0] vpos;
    logic half_phase;
  } wmap_fetch_t;

  typedef struct packed {
    logic valid;
    logic [WMAP_ADDR_W-1:0] addr;
    logic [2:0] plane_en;
    logic background;
    logic win_hit;
    logic [1:0] win_id;
  } wmap_pix_t;
endpackage

// ### testbench/wmap_mapper_assertions.sv
// assertions for the window mapper, bound to its top module
// assumes one clock domain and reset held low for at least one edge
`timescale 1ns/10ps
module wmap_mapper_assertions (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire wmap_pkg::wmap_io_t i_io,
  input wire wmap_pkg::wmap_map_wr_t i_map_wr,
  input wire wmap_pkg::wmap_fetch_t i_fetch,
  input wire logic i_mode_320,
  input wire logic i_mode_half_dot,
  input wire wmap_pkg::wmap_pix_t o_pix,
  input wire logic [3:0] o_reg_index
);
  import wmap_pkg::*;
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic idx_wr;
  logic dat_wr;
  assign idx_wr = i_io.wr && i_io.addr == WMAP_IO_INDEX;
  assign dat_wr = i_io.wr && i_io.addr == WMAP_IO_DATA;
  a_fetch_latency: assert property (i_fetch.valid |-> ##2 o_pix.valid) else $error("late pix");
  a_no_spurious: assert property (o_pix.valid |-> $past(i_fetch.valid, 2)) else $error("extra pix");
  a_index_load: assert property (idx_wr |=> o_reg_index == $past(i_io.data[3:0])) else $error("index load");
  a_index_step: assert property (dat_wr |=> o_reg_index == $past(o_reg_index) + 4'h1) else $error("index step");
  a_index_hold: assert property (!idx_wr && !dat_wr |=> $stable(o_reg_index)) else $error("index moved");
  a_pass_addr: assert property (o_pix.valid && !o_pix.win_hit |-> o_pix.addr == $past(i_fetch.addr, 2))
    else $error("pass addr");
  a_hit_bg: assert property (o_pix.valid && o_pix.win_hit |-> o_pix.background == (o_pix.plane_en == 3'h0))
    else $error("bg select");
  // background is refreshed on idle cycles too, so only its tie to the plane enables is checked
  a_bg_dark: assert property (o_pix.background |-> o_pix.plane_en == 3'h0) else $error("bg");
  c_hit: cover property (o_pix.valid && o_pix.win_hit);
  c_wrap: cover property (dat_wr && o_reg_index == 4'hF);
  c_bg: cover property (o_pix.background);
endmodule

bind wmap_mapper wmap_mapper_assertions chk_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_io(i_io),
  .i_map_wr(i_map_wr), .i_fetch(i_fetch), .i_mode_320(i_mode_320), .i_mode_half_dot(i_mode_half_dot),
  .o_pix(o_pix), .o_reg_index(o_reg_index));

// ### testbench/wmap_gdc_model.sv
// display controller stand-in: mapping ram writes and display fetches
// assumes its tasks are called from one process
`timescale 1ns/10ps
module wmap_gdc_model (
  input wire logic i_clk_sys,
  output wmap_pkg::wmap_map_wr_t o_map_wr,
  output wmap_pkg::wmap_fetch_t o_fetch
);
  import wmap_pkg::*;
  initial begin
    o_map_wr = '0;
    o_fetch = '0;
  end
  // both maps written back to back with zeros before any display fetch
  task automatic clear_maps;
    for (int i = 0; i < 4096; i++) begin
      @(posedge i_clk_sys);
      o_map_wr <= '{1'b1, i[11], i[10:0], 4'h0};
    end
    @(posedge i_clk_sys);
    o_map_wr <= '{1'b0, 1'b0, 11'h7FF, 4'hF};
  endtask
  // idle address and data fields show inverted values so stale data is never trusted
  task automatic map(input logic c, input logic [10:0] a, input logic [3:0] d);
    @(posedge i_clk_sys);
    o_map_wr <= '{1'b1, c, a, d};
    @(posedge i_clk_sys);
    o_map_wr <= '{1'b0, c, ~a, ~d};
  endtask
  task automatic fetch(input logic [17:0] a, input logic [10:0] h, input logic [9:0] v);
    @(posedge i_clk_sys);
    o_fetch <= '{1'b1, a, h, v, 1'b1};
    @(posedge i_clk_sys);
    o_fetch <= '{1'b0, ~a, ~h, ~v, 1'b0};
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the window mapper
// assumes the display controller model drives the map and fetch ports
`timescale 1ns/10ps
module testbench;
  import wmap_pkg::*;
  logic i_clk_sys;
  logic i_resetn;
  logic m320;
  logic hdot;
  wmap_io_t io;
  wmap_map_wr_t mw;
  wmap_fetch_t fe;
  wmap_pix_t pix;
  logic [3:0] idx;
  int fails;
  int checks;
  wmap_mapper dut_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_io(io), .i_map_wr(mw), .i_fetch(fe),
    .i_mode_320(m320), .i_mode_half_dot(hdot), .o_pix(pix), .o_reg_index(idx));
  wmap_gdc_model gdc_u (.i_clk_sys(i_clk_sys), .o_map_wr(mw), .o_fetch(fe));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    io <= '{1'b1, a, d};
    @(posedge i_clk_sys);
    io <= '{1'b0, 9'h1FF, ~d};
  endtask
  // win_id is only meaningful on a hit, so it is masked otherwise
  task automatic px(input logic [17:0] a, input logic [10:0] h, input logic [9:0] v, input logic [25:0] e);
    logic [25:0] g;
    gdc_u.fetch(a, h, v);
    @(posedge i_clk_sys);
    #1 g = pix;
    if (!e[2]) g[1:0] = 2'h0;
    chk(g, e);
  endtask
  task automatic t_index;
    wr(9'h110, 8'hFE);
    #1 chk(idx, 4'hE);
    wr(9'h112, 8'h55);
    #1 chk(idx, 4'hF);
    wr(9'h112, 8'h55);
    #1 chk(idx, 4'h0);
    wr(9'h114, 8'h03);
    #1 chk(idx, 4'h0);
  endtask
  task automatic t_win;
    logic [7:0] b[6] = '{8'h00, 8'h01, 8'h01, 8'h20, 8'h01, 8'h06};
    gdc_u.map(1'b0, 11'h5, 4'h6);
    gdc_u.map(1'b1, 11'h3, 4'h6);
    gdc_u.map(1'b0, 11'h6, 4'h0);
    gdc_u.map(1'b0, 11'hA, 4'h4);
    wr(9'h110, 8'h00);
    wr(9'h112, 8'h1C);
    foreach (b[i]) wr(9'h112, b[i]);
    // window 2 (priority 3) beats window 1 (priority 1); window 2 keeps reset bias and planes
    px(18'h01000, 11'h5, 10'h3, {1'b1, 18'h01000, 3'h7, 2'b01, 2'h2});
    wr(9'h110, 8'h00);
    wr(9'h112, 8'h34);
    px(18'h01000, 11'h5, 10'h3, {1'b1, 18'h01120, 3'h6, 2'b01, 2'h1});
    px(18'h01000, 11'h6, 10'h3, {1'b1, 18'h01000, 3'h0, 2'b00, 2'h0});
    m320 <= 1'b1;
    px(18'h01000, 11'h5, 10'h3, {1'b1, 18'h01000, 3'h7, 2'b01, 2'h2});
    m320 <= 1'b0;
    hdot <= 1'b1;
    px(18'h01000, 11'h5, 10'h1, {1'b1, 18'h01120, 3'h6, 2'b01, 2'h1});
    hdot <= 1'b0;
    wr(9'h110, 8'h06);
    wr(9'h112, 8'h00);
    px(18'h01000, 11'h5, 10'h3, {1'b1, 18'h01120, 3'h0, 2'b11, 2'h1});
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // map clearing takes about 4100 cycles, the scenarios under a hundred more
    #80000;
    fails++;
    final_report();
  end
  initial begin
    i_resetn = 1'b0;
    io = '0;
    m320 = 1'b0;
    hdot = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    gdc_u.clear_maps();
    t_index();
    px(18'h2ABCD, 11'h5, 10'h3, {1'b1, 18'h2ABCD, 3'h7, 2'b00, 2'h0});
    t_win();
    final_report();
  end
endmodule
